// ==== hdl/slb_status_lamps.sv ====
`timescale 1ns/1ps
`default_nettype none
module slb_status_lamps #(
    parameter int unsigned FLASH_ON_CYC    = slb_pkg::FLASH_ON_CYC,
    parameter int unsigned FLASH_OFF_CYC   = slb_pkg::FLASH_OFF_CYC,
    parameter int unsigned SHORT_PAUSE_CYC = slb_pkg::SHORT_PAUSE_CYC,
    parameter int unsigned LONG_PAUSE_CYC  = slb_pkg::LONG_PAUSE_CYC,
    parameter int unsigned PULSE_CYC       = slb_pkg::PULSE_CYC,
    parameter int unsigned BLINK_CYC       = slb_pkg::BLINK_CYC,
    parameter int unsigned SCAN_LIMIT_CYC  = slb_pkg::SCAN_LIMIT_CYC
) (
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    input  wire logic              supply_ok,
    input  wire logic              batt_low,
    input  wire logic              digital_variant,
    input  wire logic              scan_active,
    input  wire logic              scan_start,
    input  wire logic              selftest_done,
    input  wire logic              selftest_fail,
    input  wire slb_pkg::slb_err_t err_flags,
    input  wire logic [3:0]        rack_slot,
    input  wire logic [2:0]        exp_tens,
    input  wire logic [3:0]        exp_ones,
    input  wire logic [15:0]       dout_req,
    input  wire slb_pkg::slb_aout_t aout_req,
    output logic                   supply_lamp,
    output logic                   run_lamp,
    output logic                   fault_lamp,
    output logic [15:0]            dout,
    output slb_pkg::slb_aout_t     aout
);

    // ------------------------------------------------------------
    // Timing constants at counter width
    // ------------------------------------------------------------
    localparam logic [31:0] PULSE_LAST = 32'(PULSE_CYC) - slb_pkg::CNT_ONE;
    localparam logic [31:0] PULSE_HALF = 32'(PULSE_CYC / 2);
    localparam logic [31:0] BLINK_LAST = 32'(BLINK_CYC) - slb_pkg::CNT_ONE;
    localparam logic [31:0] SCAN_LAST  = 32'(SCAN_LIMIT_CYC) - slb_pkg::CNT_ONE;

    logic        testing;
    logic        hw_fault;
    logic [31:0] scan_cnt;
    logic        scan_tripped;
    logic        lost_scan;
    logic        shown_lost;
    logic [31:0] pulse_cnt;
    logic [3:0]  pwm_cnt;
    logic [31:0] blink_cnt;
    logic        blink_ph;
    logic        seq_lamp;
    logic        seq_busy;
    logic        seq_done;

    // ------------------------------------------------------------
    // Power-up self-test and lost-scan watchdog
    // ------------------------------------------------------------
    // Only the power-up result is latched; faults found afterwards are ignored
    wire hw_fail_seen = testing && selftest_done && selftest_fail;

    wire scan_trip = scan_active && !scan_start && !scan_tripped
                     && (scan_cnt == SCAN_LAST);

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            testing  <= 1'b1;
            hw_fault <= 1'b0;
        end else begin
            testing  <= testing && !selftest_done;
            hw_fault <= hw_fault || hw_fail_seen;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            scan_cnt     <= slb_pkg::CNT_ZERO;
            scan_tripped <= 1'b0;
        end else if (scan_start) begin
            scan_cnt     <= slb_pkg::CNT_ZERO;
            scan_tripped <= 1'b0;
        end else if (scan_active && !scan_tripped) begin
            scan_cnt     <= scan_cnt + slb_pkg::CNT_ONE;
            scan_tripped <= scan_trip;
        end
    end

    // ------------------------------------------------------------
    // Code selection, fixed priority
    // ------------------------------------------------------------
    wire batt_code = batt_low && digital_variant;

    wire slb_pkg::slb_code_t rack_code = '{first:  slb_pkg::RACK_DIGIT,
                                           second: slb_pkg::RACK_DIGIT,
                                           third:  slb_pkg::slb_digit(rack_slot)};
    wire slb_pkg::slb_code_t exp_code  = '{first:  slb_pkg::EXP_DIGIT,
                                           second: slb_pkg::slb_digit({1'b0, exp_tens}),
                                           third:  slb_pkg::slb_digit(exp_ones)};

    // One-shot event; a new trip wins over its clear
    wire lost_clear = seq_done && shown_lost;
    // Masked while clearing, or a shown 123 would restart
    wire lost_pend  = lost_scan && !lost_clear;

    wire any_pend = lost_pend || err_flags.overhead || err_flags.memory || err_flags.driver
                    || err_flags.rack || err_flags.expansion || batt_code;

    wire slb_pkg::slb_code_t sel_code =
        lost_pend          ? slb_pkg::CODE_LOST_SCAN :
        err_flags.overhead ? slb_pkg::CODE_OVERHEAD  :
        err_flags.memory   ? slb_pkg::CODE_MEMORY    :
        err_flags.driver   ? slb_pkg::CODE_DRIVER    :
        err_flags.rack     ? rack_code               :
        err_flags.expansion ? exp_code               :
                             slb_pkg::CODE_BATTERY;

    // A new code only starts once the previous one has fully ended
    wire seq_start = run_lamp && any_pend && !seq_busy;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            lost_scan  <= 1'b0;
            shown_lost <= 1'b0;
        end else begin
            lost_scan  <= scan_trip || (lost_scan && !lost_clear);
            shown_lost <= seq_start ? lost_pend : shown_lost;
        end
    end

    slb_flash_seq #(
        .ON_CYC    (32'(FLASH_ON_CYC)),
        .OFF_CYC   (32'(FLASH_OFF_CYC)),
        .SHORT_CYC (32'(SHORT_PAUSE_CYC)),
        .LONG_CYC  (32'(LONG_PAUSE_CYC))
    ) u_seq (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .start   (seq_start),
        .code    (sel_code),
        .lamp    (seq_lamp),
        .busy    (seq_busy),
        .done    (seq_done)
    );

    // ------------------------------------------------------------
    // Bright-dim pulse and battery blink timers
    // ------------------------------------------------------------
    // Dim half is a low-duty PWM; the lamp driver filters it as brightness
    wire pulse_lamp = (pulse_cnt < PULSE_HALF) || (pwm_cnt < slb_pkg::DIM_DUTY);
    wire pulse_wrap = (pulse_cnt == PULSE_LAST);
    wire blink_wrap = (blink_cnt == BLINK_LAST);

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pulse_cnt <= slb_pkg::CNT_ZERO;
            pwm_cnt   <= 4'h0;
            blink_cnt <= slb_pkg::CNT_ZERO;
            blink_ph  <= 1'b0;
        end else begin
            pulse_cnt <= pulse_wrap ? slb_pkg::CNT_ZERO : pulse_cnt + slb_pkg::CNT_ONE;
            pwm_cnt   <= pwm_cnt + 4'h1;
            blink_cnt <= blink_wrap ? slb_pkg::CNT_ZERO : blink_cnt + slb_pkg::CNT_ONE;
            blink_ph  <= blink_wrap ? !blink_ph : blink_ph;
        end
    end

    // ------------------------------------------------------------
    // Lamp and output drive
    // ------------------------------------------------------------
    wire blink_supply = batt_low && !digital_variant;
    wire next_supply  = supply_ok && (!blink_supply || blink_ph);

    wire next_run = scan_active;

    wire next_fault = testing                ? 1'b1       :
                      hw_fault               ? 1'b1       :
                      !run_lamp              ? 1'b0       :
                      err_flags.software     ? pulse_lamp :
                                               seq_lamp;

    // Gate on the same next value as the run lamp so they switch together
    wire [15:0]          next_dout = next_run ? dout_req : 16'h0000;
    wire slb_pkg::slb_aout_t next_aout = next_run ? aout_req : '0;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            supply_lamp <= 1'b0;
            run_lamp    <= 1'b0;
            fault_lamp  <= 1'b0;
            dout        <= 16'h0000;
            aout        <= '0;
        end else begin
            supply_lamp <= next_supply;
            run_lamp    <= next_run;
            fault_lamp  <= next_fault;
            dout        <= next_dout;
            aout        <= next_aout;
        end
    end

endmodule
`default_nettype wire

// ==== common/slb_pkg.sv ====
`default_nettype none
package slb_pkg;

    // ------------------------------------------------------------
    // Clock and display timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_KHZ        = 200000;
    localparam int unsigned FLASH_ON_MS    = 250;
    localparam int unsigned FLASH_OFF_MS   = 250;
    localparam int unsigned SHORT_PAUSE_MS = 750;
    localparam int unsigned LONG_PAUSE_MS  = 2000;
    localparam int unsigned PULSE_MS       = 1000;
    localparam int unsigned BLINK_MS       = 500;
    localparam int unsigned SCAN_LIMIT_MS  = 200;

    localparam int unsigned FLASH_ON_CYC    = FLASH_ON_MS * CLK_KHZ;
    localparam int unsigned FLASH_OFF_CYC   = FLASH_OFF_MS * CLK_KHZ;
    localparam int unsigned SHORT_PAUSE_CYC = SHORT_PAUSE_MS * CLK_KHZ;
    localparam int unsigned LONG_PAUSE_CYC  = LONG_PAUSE_MS * CLK_KHZ;
    localparam int unsigned PULSE_CYC       = PULSE_MS * CLK_KHZ;
    localparam int unsigned BLINK_CYC       = BLINK_MS * CLK_KHZ;
    localparam int unsigned SCAN_LIMIT_CYC  = SCAN_LIMIT_MS * CLK_KHZ;

    // Dim level of the pulsing fault lamp, out of 16 sub-cycles
    localparam logic [3:0]  DIM_DUTY = 4'h3;
    localparam logic [3:0]  TEN_FLASHES = 4'ha;
    localparam logic [1:0]  LAST_DIGIT = 2'h2;
    localparam logic [31:0] CNT_ZERO = 32'h0;
    localparam logic [31:0] CNT_ONE  = 32'h1;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] first;
        logic [3:0] second;
        logic [3:0] third;
    } slb_code_t;

    typedef struct packed {
        logic overhead;
        logic memory;
        logic driver;
        logic rack;
        logic expansion;
        logic software;
    } slb_err_t;

    typedef logic [3:0][15:0] slb_aout_t;

    typedef enum logic [2:0] {
        SEQ_IDLE  = 3'h0,
        SEQ_LEAD  = 3'h1,
        SEQ_ON    = 3'h3,
        SEQ_OFF   = 3'h2,
        SEQ_PAUSE = 3'h6,
        SEQ_TRAIL = 3'h7
    } slb_seq_t;

    // ------------------------------------------------------------
    // Error codes, first digit shown first
    // ------------------------------------------------------------
    localparam slb_code_t CODE_LOST_SCAN = '{first: 4'h1, second: 4'h2, third: 4'h3};
    localparam slb_code_t CODE_OVERHEAD  = '{first: 4'h1, second: 4'h2, third: 4'h4};
    localparam slb_code_t CODE_MEMORY    = '{first: 4'h1, second: 4'h2, third: 4'h5};
    localparam slb_code_t CODE_DRIVER    = '{first: 4'h2, second: 4'h2, third: 4'h2};
    localparam slb_code_t CODE_BATTERY   = '{first: 4'h6, second: 4'h2, third: 4'h1};
    localparam logic [3:0] RACK_DIGIT    = 4'h2;
    localparam logic [3:0] EXP_DIGIT     = 4'h3;

    // A zero digit cannot be shown as no flashes, so it becomes ten
    function automatic logic [3:0] slb_digit(input logic [3:0] v);
        slb_digit = (v == 4'h0) ? TEN_FLASHES : v;
    endfunction

endpackage
`default_nettype wire

// ==== hdl/slb_flash_seq.sv ====
`timescale 1ns/1ps
`default_nettype none
module slb_flash_seq #(
    parameter logic [31:0] ON_CYC    = 32'h10,
    parameter logic [31:0] OFF_CYC   = 32'h10,
    parameter logic [31:0] SHORT_CYC = 32'h20,
    parameter logic [31:0] LONG_CYC  = 32'h40
) (
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    input  wire logic              start,
    input  wire slb_pkg::slb_code_t code,
    output logic                   lamp,
    output logic                   busy,
    output logic                   done
);

    slb_pkg::slb_seq_t  state;
    slb_pkg::slb_seq_t  next_state;
    logic [31:0]        cnt;
    logic [31:0]        next_cnt;
    logic [1:0]         idx;
    logic [1:0]         next_idx;
    logic [3:0]         left;
    logic [3:0]         next_left;
    slb_pkg::slb_code_t code_q;
    slb_pkg::slb_code_t next_code;

    wire        timer_end  = (cnt == slb_pkg::CNT_ZERO);
    wire [3:0]  next_digit = (idx == 2'h0) ? code_q.second : code_q.third;

    assign busy = (state != slb_pkg::SEQ_IDLE);

    // ------------------------------------------------------------
    // Sequence: long pause, digit groups split by short pauses, long pause
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_cnt   = timer_end ? cnt : cnt - slb_pkg::CNT_ONE;
        next_idx   = idx;
        next_left  = left;
        next_code  = code_q;
        case (state)
            slb_pkg::SEQ_IDLE: begin
                next_cnt = slb_pkg::CNT_ZERO;
                if (start) begin
                    next_state = slb_pkg::SEQ_LEAD;
                    next_cnt   = LONG_CYC - slb_pkg::CNT_ONE;
                    next_code  = code;
                    next_idx   = 2'h0;
                end
            end
            slb_pkg::SEQ_LEAD: begin
                if (timer_end) begin
                    next_state = slb_pkg::SEQ_ON;
                    next_cnt   = ON_CYC - slb_pkg::CNT_ONE;
                    next_left  = code_q.first;
                end
            end
            slb_pkg::SEQ_ON: begin
                if (timer_end) begin
                    if (left > 4'h1) begin
                        next_state = slb_pkg::SEQ_OFF;
                        next_cnt   = OFF_CYC - slb_pkg::CNT_ONE;
                        next_left  = left - 4'h1;
                    end else if (idx != slb_pkg::LAST_DIGIT) begin
                        next_state = slb_pkg::SEQ_PAUSE;
                        next_cnt   = SHORT_CYC - slb_pkg::CNT_ONE;
                        next_idx   = idx + 2'h1;
                        next_left  = next_digit;
                    end else begin
                        next_state = slb_pkg::SEQ_TRAIL;
                        next_cnt   = LONG_CYC - slb_pkg::CNT_ONE;
                    end
                end
            end
            slb_pkg::SEQ_OFF, slb_pkg::SEQ_PAUSE: begin
                if (timer_end) begin
                    next_state = slb_pkg::SEQ_ON;
                    next_cnt   = ON_CYC - slb_pkg::CNT_ONE;
                end
            end
            slb_pkg::SEQ_TRAIL: begin
                if (timer_end) begin
                    next_state = slb_pkg::SEQ_IDLE;
                end
            end
            default: begin
                next_state = slb_pkg::SEQ_IDLE;
                next_cnt   = slb_pkg::CNT_ZERO;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state  <= slb_pkg::SEQ_IDLE;
            cnt    <= slb_pkg::CNT_ZERO;
            idx    <= 2'h0;
            left   <= 4'h0;
            code_q <= '0;
            lamp   <= 1'b0;
            done   <= 1'b0;
        end else begin
            state  <= next_state;
            cnt    <= next_cnt;
            idx    <= next_idx;
            left   <= next_left;
            code_q <= next_code;
            lamp   <= (next_state == slb_pkg::SEQ_ON);
            done   <= (state == slb_pkg::SEQ_TRAIL) && timer_end;
        end
    end

endmodule
`default_nettype wire

// ==== testbench/slb_status_lamps_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module slb_lamp_props #(
    parameter int unsigned BLINK_CYC = 8
) (
    input  wire logic               mclk,
    input  wire logic               sys_rst,
    input  wire logic               supply_ok,
    input  wire logic               batt_low,
    input  wire logic               digital_variant,
    input  wire logic               scan_active,
    input  wire logic               selftest_done,
    input  wire logic               selftest_fail,
    input  wire logic [15:0]        dout_req,
    input  wire logic               supply_lamp,
    input  wire logic               run_lamp,
    input  wire logic               fault_lamp,
    input  wire logic [15:0]        dout,
    input  wire slb_pkg::slb_aout_t aout
);
    // ----------------------------------------
    // Helper state
    // ----------------------------------------
    logic        testing_q;
    logic        hw_q;
    logic [31:0] same_cnt;
    wire         blinking = supply_ok && batt_low && !digital_variant;

    // Only the first self-test result counts, later ones are ignored
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            testing_q <= 1'b1;
            hw_q      <= 1'b0;
        end else if (selftest_done && testing_q) begin
            testing_q <= 1'b0;
            hw_q      <= selftest_fail;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            same_cnt <= 32'h0;
        end else if (blinking && supply_lamp == $past(supply_lamp)) begin
            same_cnt <= same_cnt + 32'h1;
        end else begin
            same_cnt <= 32'h0;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    AST_RUN_LAMP: assert property (!$past(sys_rst) |-> run_lamp == $past(scan_active))
        else $error("run lamp does not follow the scan");
    AST_OUT_OFF: assert property (!run_lamp |-> dout == 16'h0 && aout == '0)
        else $error("outputs live while run lamp dark");
    AST_OUT_PASS: assert property (run_lamp && !$past(sys_rst) |-> dout == $past(dout_req))
        else $error("discrete outputs not passed while running");
    AST_SUPPLY_OFF: assert property (!$past(supply_ok) && !$past(sys_rst) |-> !supply_lamp)
        else $error("supply lamp lit on bad supply");
    AST_SUPPLY_ON: assert property ($past(supply_ok) && !$past(batt_low) && !$past(sys_rst) |-> supply_lamp)
        else $error("supply lamp dark on good supply");
    AST_SUPPLY_DIG: assert property ($past(supply_ok) && $past(digital_variant) && !$past(sys_rst) |-> supply_lamp)
        else $error("digital variant blinks the supply lamp");
    AST_BLINK: assert property (same_cnt <= BLINK_CYC + 2)
        else $error("supply lamp stopped blinking on low battery");
    AST_TESTING: assert property (testing_q && !$past(sys_rst) |-> fault_lamp)
        else $error("fault lamp dark during self-test");
    AST_RESULT: assert property ($past(selftest_done, 2) && $past(testing_q, 2) && !$past(sys_rst, 2)
        |-> fault_lamp == ($past(selftest_fail, 2) || $past(run_lamp) && fault_lamp))
        else $error("fault lamp does not show self-test result");
    AST_HW_STEADY: assert property (hw_q |-> fault_lamp)
        else $error("hardware fault lamp not steady");
    AST_DARK: assert property (!testing_q && !hw_q && !$past(testing_q) && !run_lamp && !$past(run_lamp) |-> !fault_lamp)
        else $error("fault lamp lit while idle and not running");

    cover property (hw_q && run_lamp);
    cover property (blinking && $fell(supply_lamp));
    cover property (run_lamp && dout != 16'h0);
endmodule

bind slb_status_lamps slb_lamp_props #(.BLINK_CYC(BLINK_CYC)) u_props (
    .mclk            (mclk),
    .sys_rst         (sys_rst),
    .supply_ok       (supply_ok),
    .batt_low        (batt_low),
    .digital_variant (digital_variant),
    .scan_active     (scan_active),
    .selftest_done   (selftest_done),
    .selftest_fail   (selftest_fail),
    .dout_req        (dout_req),
    .supply_lamp     (supply_lamp),
    .run_lamp        (run_lamp),
    .fault_lamp      (fault_lamp),
    .dout            (dout),
    .aout            (aout)
);
`default_nettype wire

// ==== testbench/slb_lamp_observer.sv ====
`timescale 1ns/1ps
`default_nettype none
module slb_lamp_observer #(
    parameter int OFF_CYC  = 4,
    parameter int LONG_CYC = 16
) (
    input  wire logic              mclk,
    input  wire logic              run_lamp,
    input  wire logic              fault_lamp,
    output var slb_pkg::slb_code_t code,
    output var int                 ncodes
);
    // ----------------------------------------
    // Operator reading flash codes
    // ----------------------------------------
    logic        prev;
    logic [3:0]  cnt;
    logic [11:0] digs;
    int          off_run;

    initial begin
        prev = 1'b0;
        cnt = 4'h0;
        digs = 12'h0;
        off_run = 0;
        code = '0;
        ncodes = 0;
    end

    // Looks at the lamp mid-cycle, as an eye would, so edge updates have settled
    always @(negedge mclk) begin
        if (!run_lamp) begin
            cnt = 4'h0;
            digs = 12'h0;
            off_run = 0;
        end else if (fault_lamp) begin
            if (!prev && off_run > OFF_CYC && cnt != 4'h0) begin
                digs = {digs[7:0], cnt};
                cnt = 4'h0;
            end
            if (!prev) cnt = cnt + 4'h1;
            off_run = 0;
        end else begin
            off_run = off_run + 1;
            if (off_run == LONG_CYC && cnt != 4'h0) begin
                code = {digs[7:0], cnt};
                ncodes = ncodes + 1;
                cnt = 4'h0;
                digs = 12'h0;
            end
        end
        prev = fault_lamp;
    end
endmodule
`default_nettype wire

// ==== testbench/test_status_lamp_blink_code.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_status_lamp_blink_code;
    logic               mclk, sys_rst, supply_ok, batt_low, digital_variant, scan_active, scan_start, feed;
    logic               selftest_done, selftest_fail, supply_lamp, run_lamp, fault_lamp;
    slb_pkg::slb_err_t  err_flags;
    logic [3:0]         rack_slot, exp_ones;
    logic [2:0]         exp_tens;
    logic [15:0]        dout_req, dout;
    slb_pkg::slb_aout_t aout_req, aout;
    slb_pkg::slb_code_t seen_code;
    int                 ncodes, bad_count, checks_done, cyc = 0;

`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
    $display("ERROR %s expected %0h seen %0h", what, exp, got); end end

    localparam int FL = 4, SP = 8, LP = 16, PU = 32, BL = 8, WD = 50;
    slb_status_lamps #(.FLASH_ON_CYC(FL), .FLASH_OFF_CYC(FL), .SHORT_PAUSE_CYC(SP), .LONG_PAUSE_CYC(LP),
        .PULSE_CYC(PU), .BLINK_CYC(BL), .SCAN_LIMIT_CYC(WD)) u_dut (
        .mclk(mclk), .sys_rst(sys_rst), .supply_ok(supply_ok), .batt_low(batt_low),
        .digital_variant(digital_variant), .scan_active(scan_active), .scan_start(scan_start),
        .selftest_done(selftest_done), .selftest_fail(selftest_fail), .err_flags(err_flags),
        .rack_slot(rack_slot), .exp_tens(exp_tens), .exp_ones(exp_ones), .dout_req(dout_req),
        .aout_req(aout_req), .supply_lamp(supply_lamp), .run_lamp(run_lamp), .fault_lamp(fault_lamp),
        .dout(dout), .aout(aout));

    slb_lamp_observer #(.OFF_CYC(FL), .LONG_CYC(LP)) u_eye (
        .mclk(mclk), .run_lamp(run_lamp), .fault_lamp(fault_lamp), .code(seen_code), .ncodes(ncodes));

    // ----------------------------------------
    // Clock, scan feeder and hang guard
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // Scans restart every 20 cycles while fed, well inside the watchdog limit
    always @(negedge mclk) begin
        cyc <= cyc + 1;
        scan_start <= feed && (cyc % 20 == 0);
        if (cyc == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (bad_count == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic pulse_done(input logic fail);
        selftest_fail = fail;
        selftest_done = 1'b1;
        tick(1);
        selftest_done = 1'b0;
    endtask

    task automatic wait_flash(output int t);
        t = 0;
        while (fault_lamp !== 1'b0 && t < 600) begin tick(1); t++; end
        while (fault_lamp !== 1'b1 && t < 600) begin tick(1); t++; end
        `CHK("flash start", 1'b1, fault_lamp)
    endtask

    // Flags drop once the code is under way: a started code must still finish
    task automatic run_code(input slb_pkg::slb_err_t f, keep, input logic bl, input logic [11:0] exp);
        int n, t, w;
        n = ncodes;
        err_flags = f;
        batt_low = bl;
        digital_variant = bl;
        wait_flash(t);
        `CHK("supply lamp", 1'b1, supply_lamp)
        err_flags = keep;
        batt_low = 1'b0;
        w = 0;
        while (ncodes == n && w < 2000) begin tick(1); w++; end
        `CHK("code", exp, seen_code)
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_selftest();
        tick(3);
        `CHK("testing lamp", 1'b1, fault_lamp)
        pulse_done(1'b0);
        tick(1);
        `CHK("pass lamp", 1'b0, fault_lamp)
    endtask

    task automatic t_outputs();
        feed = 1'b1;
        dout_req = 16'ha5c3;
        aout_req = {16'h8001, 16'h7ffe, 16'h0001, 16'hffff};
        tick(3);
        `CHK("run idle", 1'b0, run_lamp)
        `CHK("dout idle", 16'h0, dout)
        `CHK("aout idle", 64'h0, aout)
        scan_active = 1'b1;
        tick(2);
        `CHK("run on", 1'b1, run_lamp)
        `CHK("dout on", 16'ha5c3, dout)
        `CHK("aout on", aout_req, aout)
        pulse_done(1'b1);
        tick(4);
        `CHK("late fault", 1'b0, fault_lamp)
        scan_active = 1'b0;
        tick(2);
        `CHK("dout stop", 16'h0, dout)
        scan_active = 1'b1;
        tick(2);
    endtask

    task automatic t_supply();
        int tg;
        logic p;
        supply_ok = 1'b0;
        tick(2);
        `CHK("supply bad", 1'b0, supply_lamp)
        supply_ok = 1'b1;
        tick(2);
        `CHK("supply good", 1'b1, supply_lamp)
        batt_low = 1'b1;
        tg = 0;
        p = supply_lamp;
        repeat (40) begin
            tick(1);
            if (supply_lamp !== p) tg++;
            p = supply_lamp;
        end
        `CHK("supply toggles", 1'b1, tg >= 4 && tg <= 6)
        batt_low = 1'b0;
    endtask

    task automatic t_codes();
        run_code(6'h30, 6'h10, 1'b0, 12'h124);
        run_code(6'h10, 6'h00, 1'b0, 12'h125);
        run_code(6'h08, 6'h00, 1'b0, 12'h222);
        rack_slot = 4'h3;
        run_code(6'h04, 6'h00, 1'b0, 12'h223);
        exp_tens = 3'h3;
        exp_ones = 4'h0;
        run_code(6'h02, 6'h00, 1'b0, 12'h33a);
        exp_tens = 3'h0;
        exp_ones = 4'h9;
        run_code(6'h02, 6'h00, 1'b0, 12'h3a9);
        run_code(6'h00, 6'h00, 1'b1, 12'h621);
        digital_variant = 1'b0;
    endtask

    task automatic t_lost_scan();
        int n, t;
        n = ncodes;
        while (scan_start !== 1'b1) tick(1);
        feed = 1'b0;
        wait_flash(t);
        `CHK("lost scan delay", 1'b1, t >= 66 && t <= 80)
        feed = 1'b1;
        t = 0;
        while (ncodes == n && t < 2000) begin tick(1); t++; end
        `CHK("lost scan code", 12'h123, seen_code)
        tick(120);
        `CHK("lost scan once", n + 1, ncodes)
    endtask

    task automatic t_software();
        int on;
        err_flags = 6'h01;
        tick(40);
        on = 0;
        repeat (32) begin
            tick(1);
            on += fault_lamp;
        end
        `CHK("pulse bright dim", 1'b1, on > 16 && on < 32)
        err_flags = 6'h00;
    endtask

    task automatic t_hw_fault();
        sys_rst = 1'b1;
        tick(2);
        sys_rst = 1'b0;
        tick(2);
        pulse_done(1'b1);
        tick(20);
        `CHK("hw fault steady", 2'b11, {run_lamp, fault_lamp})
    endtask

    initial begin
        {sys_rst, supply_ok} = 2'b11;
        {batt_low, digital_variant, scan_active, feed, selftest_done, selftest_fail} = 6'h00;
        err_flags = 6'h00;
        {rack_slot, exp_tens, exp_ones} = 11'h000;
        dout_req = 16'h0;
        aout_req = '0;
        {bad_count, checks_done} = {32'h0, 32'h0};
        tick(10);
        `CHK("lamps in reset", 3'b000, {supply_lamp, run_lamp, fault_lamp})
        sys_rst = 1'b0;
        t_selftest();
        t_outputs();
        t_supply();
        t_codes();
        t_lost_scan();
        t_software();
        t_hw_fault();
        tally_and_finish();
    end
endmodule
`default_nettype wire
